// ### pkg/dvs_pkg.sv
// constants, types and decode shared by the core-rail ramp control and its stepper
package dvs_pkg;

    // register subaddresses
    localparam logic [7:0] RAMP_CTL_OFS    = 8'h1a;
    localparam logic [7:0] LIN_SP_OFS      = 8'h1b;
    localparam logic [7:0] SEQ_DLY_A_OFS   = 8'h20;

    // reset values
    localparam logic [7:0] RAMP_CTL_RST    = 8'h06;
    localparam logic [7:0] LIN_SP_RST      = 8'h1f;
    localparam logic [7:0] SEQ_DLY_A_RST   = 8'h00;

    // field positions and widths
    localparam int         GO_BIT          = 7;
    localparam int         AUTO_BIT        = 6;
    localparam int         SLEW_LSB        = 0;
    localparam int         SLEW_W          = 3;
    localparam int         LIN_SP_W        = 6;
    localparam int         CODE_W          = 6;
    localparam logic [2:0] SLEW_IMMEDIATE  = 3'h7;
    localparam logic [2:0] SLEW_RST        = 3'h6;
    localparam logic [5:0] LIN_SP_CODE_RST = 6'h1f;

    // level the core rails are taken to hold before the first ramp
    localparam logic [5:0] CORE_CODE_RST   = 6'h00;

    // timing
    localparam int         CLK_PERIOD_NS   = 10;
    localparam int         DWELL_MAX_NS    = 160000;
    localparam int         DWELL_MAX_CYC   = (DWELL_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         BLANK_MS        = 5;
    localparam int         BLANK_CYC       = (BLANK_MS * 1000000 + CLK_PERIOD_NS - 1)
                                             / CLK_PERIOD_NS;
    localparam int         CNT_W           = 20;
    localparam int         NUM_RAILS       = 2;

    // one register write from the serial front end
    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } dvs_reg_wr_s;

    typedef logic [5:0] dvs_code_t;

    typedef enum logic [1:0] {
        RS_IDLE = 2'b01,
        RS_WAIT = 2'b10
    } dvs_ramp_e;

    // one-hot select: bit0 ramp control, bit1 linear setpoint, bit2 sequence delay
    function automatic logic [2:0] dvs_reg_sel(input logic [7:0] addr);
        dvs_reg_sel = {addr == SEQ_DLY_A_OFS, addr == LIN_SP_OFS, addr == RAMP_CTL_OFS};
    endfunction

endpackage

// ### src/dvs_rail_stepper.sv
// one core rail: applied code walks one code per step toward its target
`timescale 1ns/1ps
module dvs_rail_stepper (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              load,
    input  wire dvs_pkg::dvs_code_t load_code,
    input  wire logic              step,
    input  wire logic              jump,
    output dvs_pkg::dvs_code_t     present,
    output logic                   at_target
);

    dvs_pkg::dvs_code_t target_ff;
    dvs_pkg::dvs_code_t present_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            target_ff <= dvs_pkg::CORE_CODE_RST;
        end else if (load) begin
            target_ff <= load_code;
        end
    end

    // one code per step, so a coarser code table gives a faster rate [R6]
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            present_ff <= dvs_pkg::CORE_CODE_RST;
        end else if (jump) begin
            present_ff <= target_ff; // [R5]
        end else if (step && present_ff < target_ff) begin
            present_ff <= present_ff + 6'h01; // [R6]
        end else if (step && present_ff > target_ff) begin
            present_ff <= present_ff - 6'h01; // [R6]
        end
    end

    assign present   = present_ff;
    assign at_target = (present_ff == target_ff);

endmodule

// ### src/dvs_ramp_ctrl.sv
// core buck ramp control, linear regulator setpoint and supervisor blanking
//
// Overview of operation
// [R1] Writing 1 to the trigger bit ramps both core bucks to their stored setpoints at the slew rate.
// [R2] The trigger bit clears itself once both core rails have reached their targets.
// [R3] With auto-apply set, each core setpoint update starts a ramp without the trigger bit.
// [R4] Slew codes 0 to 6 give a dwell of 160 us halved per code down to 2.5 us; reset code is 6.
// [R5] Slew code 7 applies the new setpoint at once with no dwell between codes.
// [R6] The ramp moves one setpoint code per dwell, so the rate follows each rail's code size.
// [R7] The linear regulator setpoint only changes when the password gate is open.
// [R8] Any write to the linear setpoint blanks the over- and undervoltage outputs for 5 ms.
// [R9] The 6-bit linear setpoint runs 0.900 V to 3.400 V and resets to code 1f (1.800 V).
// [R10] Slew and trigger act on the two core bucks only, never on other rails.
// [R11] Software clears pulse-skip on both core bucks before lowering them in tight window mode.
// [R12] Reserved bits of ramp control and linear setpoint read zero and ignore writes.
`timescale 1ns/1ps
module dvs_ramp_ctrl #(
    parameter int DWELL_MAX_CYC_P = dvs_pkg::DWELL_MAX_CYC,
    parameter int BLANK_CYC_P     = dvs_pkg::BLANK_CYC
) (
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire dvs_pkg::dvs_reg_wr_s reg_wr,
    input  wire logic [7:0]         rd_addr,
    output logic [7:0]              rd_data,
    input  wire logic               pw_ok,
    input  wire dvs_pkg::dvs_code_t core_sp_one,
    input  wire dvs_pkg::dvs_code_t core_sp_two,
    input  wire logic [1:0]         core_sp_upd,
    output dvs_pkg::dvs_code_t      core_buck_one,
    output dvs_pkg::dvs_code_t      core_buck_two,
    output logic                    ramp_busy,
    output logic [5:0]              linear_reg_one,
    output logic [7:0]              sequence_delay_reg_a,
    input  wire logic               ov_raw,
    input  wire logic               uv_raw,
    output logic                    ov_flag,
    output logic                    uv_flag,
    output logic                    blank_active
);

    // register state
    logic                 go_ff;
    logic                 auto_apply_setpoint_ff;
    logic [2:0]           slew_ff;
    logic [5:0]           lin_sp_ff;
    logic [7:0]           seq_dly_a_ff;
    logic [7:0]           rd_data_ff;

    // ramp sequencing
    dvs_pkg::dvs_ramp_e   state_ff;
    dvs_pkg::dvs_ramp_e   nxt_state;
    logic [dvs_pkg::CNT_W-1:0] dwell_cnt_ff;
    logic [dvs_pkg::CNT_W-1:0] dwell_len;
    logic [dvs_pkg::CNT_W-1:0] blank_cnt_ff;

    // supervisor outputs
    logic                 ov_flag_ff;
    logic                 uv_flag_ff;

    logic [2:0]           wr_sel;
    logic                 wr_ramp;
    logic                 wr_lin;
    logic                 wr_seq;
    logic                 go_write;
    logic                 auto_start;
    logic                 start;
    logic                 imm;
    logic                 all_at_target;
    logic                 finish;
    logic                 step;
    logic                 jump;
    logic [2:0]           slew_eff;
    logic [2:0]           rd_sel;

    dvs_pkg::dvs_code_t   sp_in   [dvs_pkg::NUM_RAILS];
    dvs_pkg::dvs_code_t   present [dvs_pkg::NUM_RAILS];
    logic [dvs_pkg::NUM_RAILS-1:0] at_target;

    assign wr_sel  = dvs_pkg::dvs_reg_sel(reg_wr.addr);
    assign wr_ramp = reg_wr.en && wr_sel[0];
    assign wr_lin  = reg_wr.en && wr_sel[1];
    assign wr_seq  = reg_wr.en && wr_sel[2];

    assign go_write   = wr_ramp && reg_wr.data[dvs_pkg::GO_BIT]; // [R1]
    assign auto_start = auto_apply_setpoint_ff && (|core_sp_upd); // [R3]
    assign start      = go_write || auto_start;
    assign imm        = (slew_ff == dvs_pkg::SLEW_IMMEDIATE);

    // ramp control fields; reserved bits 5..3 are never stored
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            auto_apply_setpoint_ff <= dvs_pkg::RAMP_CTL_RST[dvs_pkg::AUTO_BIT];
            slew_ff                <= dvs_pkg::SLEW_RST; // [R4]
        end else if (wr_ramp) begin
            auto_apply_setpoint_ff <= reg_wr.data[dvs_pkg::AUTO_BIT]; // [R3]
            slew_ff                <= reg_wr.data[dvs_pkg::SLEW_LSB +: dvs_pkg::SLEW_W]; // [R12]
        end
    end

    // trigger: a fresh write of 1 wins over the completion clear; writing 0 changes nothing
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            go_ff <= dvs_pkg::RAMP_CTL_RST[dvs_pkg::GO_BIT];
        end else if (go_write) begin
            go_ff <= 1'b1; // [R1]
        end else if (finish) begin
            go_ff <= 1'b0; // [R2]
        end
    end

    // password-gated setpoint and sequence delay storage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lin_sp_ff <= dvs_pkg::LIN_SP_CODE_RST; // [R9]
        end else if (wr_lin && pw_ok) begin
            lin_sp_ff <= reg_wr.data[dvs_pkg::LIN_SP_W-1:0]; // [R7] [R12]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            seq_dly_a_ff <= dvs_pkg::SEQ_DLY_A_RST;
        end else if (wr_seq && pw_ok) begin
            seq_dly_a_ff <= reg_wr.data;
        end
    end

    // dwell per code: base time halved once per slew code
    // go and a new slew code in one byte: the first dwell must already use the new code
    assign slew_eff  = wr_ramp ? reg_wr.data[dvs_pkg::SLEW_LSB +: dvs_pkg::SLEW_W] : slew_ff;
    assign dwell_len = dvs_pkg::CNT_W'(DWELL_MAX_CYC_P >> slew_eff); // [R4]

    assign all_at_target = &at_target;
    assign finish = (state_ff == dvs_pkg::RS_WAIT) && all_at_target && !start; // [R2]
    assign jump   = (state_ff == dvs_pkg::RS_WAIT) && imm && !start; // [R5]
    assign step   = (state_ff == dvs_pkg::RS_WAIT) && !imm && !start
                    && (dwell_cnt_ff == '0); // [R4]

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            dvs_pkg::RS_IDLE: begin
                if (start) begin
                    nxt_state = dvs_pkg::RS_WAIT; // [R1] [R3]
                end
            end
            dvs_pkg::RS_WAIT: begin
                if (finish) begin
                    nxt_state = dvs_pkg::RS_IDLE;
                end
            end
            default: begin
                nxt_state = dvs_pkg::RS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= dvs_pkg::RS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // a retarget during a ramp restarts the dwell so no step comes early
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dwell_cnt_ff <= '0;
        end else if (start || step) begin
            dwell_cnt_ff <= dwell_len - dvs_pkg::CNT_W'(1); // [R4]
        end else if (state_ff == dvs_pkg::RS_WAIT && dwell_cnt_ff != '0) begin
            dwell_cnt_ff <= dwell_cnt_ff - dvs_pkg::CNT_W'(1);
        end
    end

    // only the two core bucks are stepped here
    assign sp_in[0] = core_sp_one; // [R10]
    assign sp_in[1] = core_sp_two; // [R10]

    generate
        for (genvar i = 0; i < dvs_pkg::NUM_RAILS; i++) begin : g_rail
            dvs_rail_stepper u_step (
                .clk_sys   (clk_sys),
                .rst       (rst),
                .load      (start),
                .load_code (sp_in[i]),
                .step      (step),
                .jump      (jump),
                .present   (present[i]),
                .at_target (at_target[i])
            );
        end
    endgenerate

    // blanking runs from any linear setpoint write, accepted or refused by the gate
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            blank_cnt_ff <= '0;
        end else if (wr_lin) begin
            blank_cnt_ff <= dvs_pkg::CNT_W'(BLANK_CYC_P); // [R8]
        end else if (blank_cnt_ff != '0) begin
            blank_cnt_ff <= blank_cnt_ff - dvs_pkg::CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ov_flag_ff <= 1'b0;
            uv_flag_ff <= 1'b0;
        end else begin
            ov_flag_ff <= ov_raw && (blank_cnt_ff == '0) && !wr_lin; // [R8]
            uv_flag_ff <= uv_raw && (blank_cnt_ff == '0) && !wr_lin; // [R8]
        end
    end

    // read-back; unmapped subaddresses read zero
    assign rd_sel = dvs_pkg::dvs_reg_sel(rd_addr);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_data_ff <= 8'h00;
        end else begin
            unique case (1'b1)
                rd_sel[0]:
                    rd_data_ff <= {go_ff, auto_apply_setpoint_ff, 3'h0, slew_ff}; // [R12]
                rd_sel[1]:
                    rd_data_ff <= {2'h0, lin_sp_ff}; // [R12]
                rd_sel[2]:
                    rd_data_ff <= seq_dly_a_ff;
                default:
                    rd_data_ff <= 8'h00;
            endcase
        end
    end

    assign rd_data              = rd_data_ff;
    assign core_buck_one        = present[0];
    assign core_buck_two        = present[1];
    assign ramp_busy            = (state_ff == dvs_pkg::RS_WAIT);
    assign linear_reg_one       = lin_sp_ff;
    assign sequence_delay_reg_a = seq_dly_a_ff;
    assign ov_flag              = ov_flag_ff;
    assign uv_flag              = uv_flag_ff;
    assign blank_active         = (blank_cnt_ff != '0);

endmodule

// ### testbench/dvs_ramp_chk.sv
// checker for ramp control, linear setpoint gating and blanking
`timescale 1ns/1ps
module dvs_ramp_chk #(
    parameter int BLANK_CYC_P = 50
) (
    input wire logic                 clk_sys,
    input wire logic                 rst,
    input wire dvs_pkg::dvs_reg_wr_s reg_wr,
    input wire logic [7:0]           rd_addr,
    input wire logic [7:0]           rd_data,
    input wire logic                 pw_ok,
    input wire dvs_pkg::dvs_code_t   core_sp_one,
    input wire dvs_pkg::dvs_code_t   core_sp_two,
    input wire logic [1:0]           core_sp_upd,
    input wire dvs_pkg::dvs_code_t   core_buck_one,
    input wire dvs_pkg::dvs_code_t   core_buck_two,
    input wire logic                 ramp_busy,
    input wire logic [5:0]           linear_reg_one,
    input wire logic                 ov_flag,
    input wire logic                 uv_flag,
    input wire logic                 blank_active
);
    localparam int BL1 = BLANK_CYC_P - 1;
    logic       auto_ff;
    logic [7:0] wd_ff;
    logic       wr_ramp;
    logic       wr_lin;
    assign wr_ramp = reg_wr.en && reg_wr.addr == dvs_pkg::RAMP_CTL_OFS;
    assign wr_lin  = reg_wr.en && reg_wr.addr == dvs_pkg::LIN_SP_OFS;
    always_ff @(posedge clk_sys) begin
        wd_ff <= reg_wr.data;
        if (rst) begin
            auto_ff <= 1'b0;
        end else if (wr_ramp) begin
            auto_ff <= reg_wr.data[6];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_jump_done;
        ramp_busy ##1 (core_buck_one == $past(core_sp_one, 2)
            && core_buck_two == $past(core_sp_two, 2)) ##1 !ramp_busy;
    endsequence
    sequence s_blank_run;
        ##BL1 blank_active ##1 !blank_active;
    endsequence
    property p_jump;
        wr_ramp && reg_wr.data[7] && reg_wr.data[2:0] == 3'h7 && !ramp_busy |=> s_jump_done;
    endproperty
    property p_go_clr;
        !ramp_busy && !reg_wr.en && rd_addr == dvs_pkg::RAMP_CTL_OFS |=> !rd_data[7];
    endproperty
    property p_auto;
        auto_ff && core_sp_upd != 2'h0 |=> ramp_busy;
    endproperty
    property p_no_auto;
        !auto_ff && !ramp_busy && !reg_wr.en && core_sp_upd != 2'h0 |=> !ramp_busy;
    endproperty
    property p_lin_gate;
        wr_lin && !pw_ok |=> $stable(linear_reg_one);
    endproperty
    property p_lin_wr;
        wr_lin && pw_ok |=> linear_reg_one == wd_ff[5:0];
    endproperty
    property p_blank_len;
        wr_lin |=> blank_active ##0 s_blank_run;
    endproperty
    property p_flags;
        blank_active |-> !ov_flag && !uv_flag;
    endproperty
    property p_rail_only;
        wr_ramp |=> $stable(linear_reg_one);
    endproperty
    property p_rsvd;
        rd_addr == dvs_pkg::RAMP_CTL_OFS |=> rd_data[5:3] == 3'h0;
    endproperty
    a_jump: assert property (p_jump) else $error("immediate ramp wrong");
    a_go_clr: assert property (p_go_clr) else $error("trigger bit stuck");
    a_auto: assert property (p_auto) else $error("auto start missing");
    a_no_auto: assert property (p_no_auto) else $error("ramp without trigger");
    a_lin_gate: assert property (p_lin_gate) else $error("locked setpoint changed");
    a_lin_wr: assert property (p_lin_wr) else $error("setpoint not stored");
    a_blank_len: assert property (p_blank_len) else $error("blank length wrong");
    a_flags: assert property (p_flags) else $error("flag during blank");
    a_rail_only: assert property (p_rail_only) else $error("linear rail moved");
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
endmodule

// ### testbench/dvs_ramp_ctrl_tb.sv
// self-checking bench for core-rail ramping and linear setpoint control
`timescale 1ns/1ps
module dvs_ramp_ctrl_tb;
    localparam int DW = 64;
    localparam int BL = 50;
    logic                 clk_sys = 1'b0;
    logic                 rst = 1'b1;
    dvs_pkg::dvs_reg_wr_s reg_wr = '0;
    logic [7:0]           rd_addr = 8'h00;
    logic [7:0]           rd_data;
    logic                 pw_ok = 1'b0;
    dvs_pkg::dvs_code_t   core_sp_one = 6'h00;
    dvs_pkg::dvs_code_t   core_sp_two = 6'h00;
    logic [1:0]           core_sp_upd = 2'h0;
    dvs_pkg::dvs_code_t   core_buck_one;
    dvs_pkg::dvs_code_t   core_buck_two;
    logic                 ramp_busy;
    logic [5:0]           linear_reg_one;
    logic [7:0]           sequence_delay_reg_a;
    logic                 ov_raw = 1'b0;
    logic                 uv_raw = 1'b0;
    logic                 ov_flag;
    logic                 uv_flag;
    logic                 blank_active;
    int                   fails = 0;
    int                   comparisons = 0;
    int                   n;
    dvs_ramp_ctrl #(.DWELL_MAX_CYC_P(DW), .BLANK_CYC_P(BL)) dvs_ramp_ctrl_i (
        .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .rd_addr(rd_addr),
        .rd_data(rd_data), .pw_ok(pw_ok), .core_sp_one(core_sp_one),
        .core_sp_two(core_sp_two), .core_sp_upd(core_sp_upd),
        .core_buck_one(core_buck_one), .core_buck_two(core_buck_two),
        .ramp_busy(ramp_busy), .linear_reg_one(linear_reg_one),
        .sequence_delay_reg_a(sequence_delay_reg_a), .ov_raw(ov_raw), .uv_raw(uv_raw),
        .ov_flag(ov_flag), .uv_flag(uv_flag), .blank_active(blank_active));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic tally_and_finish;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= '{1'b1, a, d};
        @(posedge clk_sys);
        reg_wr.en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        rd_addr <= a;
        @(posedge clk_sys);
        #1;
        cmp("rd_data", exp, rd_data);
    endtask
    // update targets, optionally pulsing the per-rail update strobe
    // targets only ever rise here, so no pulse-skip clear is owed first
    task automatic setsp(input logic [5:0] s1, input logic [5:0] s2, input logic [1:0] m);
        @(posedge clk_sys);
        core_sp_one <= s1;
        core_sp_two <= s2;
        core_sp_upd <= m;
        @(posedge clk_sys);
        core_sp_upd <= 2'h0;
    endtask
    // counts edges until busy drops; bounded so a stuck ramp ends the run
    task automatic wait_idle(output int k);
        k = 0;
        #1;
        while (ramp_busy !== 1'b0 && k < 2000) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        if (k >= 2000) begin
            fails++;
            tally_and_finish();
        end
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        rd(dvs_pkg::RAMP_CTL_OFS, 8'h06);
        rd(dvs_pkg::LIN_SP_OFS, 8'h1f);
        rd(8'h55, 8'h00);
        setsp(6'h05, 6'h0a, 2'h0);
        // go, auto-apply, reserved ones and immediate slew in one byte
        wr(dvs_pkg::RAMP_CTL_OFS, 8'hff);
        wait_idle(n);
        cmp("jump span", 8'h02, n[7:0]);
        cmp("rail two", 8'h0a, {2'h0, core_buck_two});
        rd(dvs_pkg::RAMP_CTL_OFS, 8'h47);
        cmp("linear", 8'h1f, {2'h0, linear_reg_one});
        setsp(6'h08, 6'h0a, 2'h1);
        wait_idle(n);
        cmp("auto rail", 8'h08, {2'h0, core_buck_one});
        wr(dvs_pkg::RAMP_CTL_OFS, 8'h00);
        setsp(6'h09, 6'h0a, 2'h1);
        #1;
        cmp("no start", 8'h00, {7'h0, ramp_busy});
        wr(dvs_pkg::RAMP_CTL_OFS, 8'h80);
        wait_idle(n);
        cmp("slow span", 8'h01, {7'h0, n >= DW && n <= DW + 3});
        cmp("slow rail", 8'h09, {2'h0, core_buck_one});
        setsp(6'h09, 6'h10, 2'h0);
        wr(dvs_pkg::RAMP_CTL_OFS, 8'h86);
        wait_idle(n);
        cmp("fast span", 8'h01, {7'h0, n >= 6 && n <= 8});
        cmp("fast rail", 8'h10, {2'h0, core_buck_two});
        @(posedge clk_sys);
        ov_raw <= 1'b1;
        uv_raw <= 1'b1;
        wr(dvs_pkg::LIN_SP_OFS, 8'hff);
        #1;
        cmp("blank", 8'h01, {7'h0, blank_active});
        cmp("flags", 8'h00, {6'h0, ov_flag, uv_flag});
        rd(dvs_pkg::LIN_SP_OFS, 8'h1f);
        repeat (BL + 5) @(posedge clk_sys);
        cmp("flags after", 8'h03, {6'h0, ov_flag, uv_flag});
        pw_ok <= 1'b1;
        wr(dvs_pkg::LIN_SP_OFS, 8'hff);
        rd(dvs_pkg::LIN_SP_OFS, 8'h3f);
        cmp("linear", 8'h3f, {2'h0, linear_reg_one});
        repeat (BL + 5) @(posedge clk_sys);
        wr(dvs_pkg::SEQ_DLY_A_OFS, 8'ha5);
        rd(dvs_pkg::SEQ_DLY_A_OFS, 8'ha5);
        cmp("seq", 8'ha5, sequence_delay_reg_a);
        tally_and_finish();
    end
endmodule
bind dvs_ramp_ctrl dvs_ramp_chk #(.BLANK_CYC_P(BLANK_CYC_P)) dvs_ramp_chk_i (
    .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .rd_addr(rd_addr), .rd_data(rd_data),
    .pw_ok(pw_ok), .core_sp_one(core_sp_one), .core_sp_two(core_sp_two),
    .core_sp_upd(core_sp_upd), .core_buck_one(core_buck_one),
    .core_buck_two(core_buck_two), .ramp_busy(ramp_busy), .linear_reg_one(linear_reg_one),
    .ov_flag(ov_flag), .uv_flag(uv_flag), .blank_active(blank_active));
